// *** motor_setpoint_checker.sv ***
// Port checker for motor_setpoint_mode_logic.
// Assumes the constants header and one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "motor_setpoint_consts.svh"
module motor_setpoint_checker #(
	parameter int BASE_CYCLES = 10
) (
	input wire logic clk, // Clock
	input wire logic reset, // Synchronous reset
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Lanes
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic [31:0] demand_pos, // Demand position
	input wire logic [15:0] torque_demand, // Applied torque
	input wire logic torque_active // Preset followed
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ****************
	// Steps and checks
	// ****************
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_mode_wr(code);
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_MODE && wb_dat_i[7:0] == code;
	endsequence
	a_ack_wait: assert property (s_req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `OFS_ACTUAL_POS |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	// Torque only reaches the motor while following
	a_torque_gated: assert property (!torque_active |-> torque_demand == 16'h0) else $error("torque leaks");
	// Demand moves only once per interpolation cycle
	a_pos_per_cycle: assert property ($changed(demand_pos) |=> $stable(demand_pos) [*8])
		else $error("demand moved twice in a cycle");
	a_step_stops_torque: assert property (s_mode_wr(8'hFF) |=> ##1 !torque_active)
		else $error("torque kept in step mode");
	a_setup_no_torque: assert property (s_mode_wr(8'hFE) |=> ##1 torque_demand == 16'h0)
		else $error("torque kept in setup");
endmodule : motor_setpoint_checker
bind motor_setpoint_mode_logic motor_setpoint_checker #(.BASE_CYCLES(BASE_CYCLES)) chk_i (.clk(clk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .demand_pos(demand_pos),
	.torque_demand(torque_demand), .torque_active(torque_active));
`default_nettype wire

// *** motor_setpoint_consts.svh ***
// Register offsets, field positions, reset values and timing counts for motor_setpoint_mode_logic.
// Assumes a 25 MHz clock and a 32-bit classic Wishbone slave port.
// Behaviour
// (R1) Mode code 10 selects cyclic torque mode, following presets without ramps.
// (R2) Cyclic torque mode drives the motor only while closed loop is active.
// (R3) Status bit 8 shows synchronisation to the fieldbus cycle.
// (R4) Status bit 12 in torque mode shows the preset is used.
// (R5) Master writes a fresh torque preset each cycle, relative to max torque.
// (R6) Applied torque is clamped to min of max torque and max current.
// (R7) Cycle length is period times 10^index; only index -3 (1 ms) works.
// (R8) Torque offset in tenths of a percent is added to the preset.
// (R9) Mode code -1 (FFh) selects step/direction pulse mode.
// (R10) Each step pulse moves demand position one scaled step in given direction.
// (R11) External pulse rate at most 1 MHz, active pulse at least 200 ns.
// (R12) Pulses are counted per cycle; demand position updates once per cycle.
// (R13) Step width is numerator over denominator; default 128/1 is a quarter step.
// (R14) External controller waits 35 us after a direction change before stepping.
// (R15) Status bit 13 sets when position error stays outside window past timeout.
// (R16) Subtype 0: clock input steps, direction input sets sense.
// (R17) Subtype 1: direction comes from which input gets the pulses.
// (R18) Mode code -2 selects the auto setup procedure.
// (R19) Auto setup starts on a 0-to-1 transition of control bit 4.
// (R20) Status bit 10 during auto setup shows an index mark was found.
// (R21) Status bit 12 sets once auto setup has completed.
// (R22) Closed loop is refused until an auto setup has completed.
// (R23) Dual pulse subtype: first input counts up, second input counts down.
`ifndef MOTOR_SETPOINT_CONSTS_SVH
`define MOTOR_SETPOINT_CONSTS_SVH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_TARGET_TORQUE 8'h0C
`define OFS_MAX_TORQUE 8'h10
`define OFS_MAX_CURRENT 8'h14
`define OFS_TORQUE_OFFSET 8'h18
`define OFS_CYCLE_PERIOD 8'h1C
`define OFS_CYCLE_INDEX 8'h20
`define OFS_STEP_NUM 8'h24
`define OFS_STEP_DEN 8'h28
`define OFS_SUBTYPE 8'h2C
`define OFS_ERR_WINDOW 8'h30
`define OFS_ERR_TIMEOUT 8'h34
`define OFS_DEMAND_POS 8'h38
`define OFS_TORQUE_DEMAND 8'h3C
`define OFS_ACTUAL_POS 8'h40

// Mode codes and the 1 ms cycle index code
`define MODE_TORQUE 8'h0A
`define MODE_STEP_DIR 8'hFF
`define MODE_AUTOSETUP 8'hFE
`define CYCLE_INDEX_MS 8'hFD

// Control and status bit positions
`define CTRL_CLOSED_LOOP 0
`define CTRL_START 4
`define ST_SYNC 8
`define ST_INDEXED 10
`define ST_FOLLOW 12
`define ST_FOLLOW_ERR 13
`define ST_CLOSED_LOOP 0

// Reset values
`define RST_STEP_NUM 32'h0000_0080
`define RST_STEP_DEN 32'h0000_0001
`define RST_CYCLE_PERIOD 16'h0001
`define RST_MAX_TORQUE 16'h03E8
`define RST_MAX_CURRENT 16'h03E8
`define RST_ERR_WINDOW 32'h0000_0100
`define RST_ERR_TIMEOUT 16'h000A

// Timing
`define CLK_HZ 25000000
`define BASE_TIME_US 1000
`define BASE_CYCLES ((`CLK_HZ / 1000000) * `BASE_TIME_US)
`define AUTOSETUP_MS 16'h0064

`endif

// *** motor_setpoint_mode_logic.sv ***
// Setpoint handling for cyclic torque, step/direction and auto setup modes.
// Assumes a classic Wishbone master, step pins already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "motor_setpoint_consts.svh"

module motor_setpoint_mode_logic #(
	parameter int BASE_CYCLES = `BASE_CYCLES
) (
	input wire logic clk, // 25 MHz clock
	input wire logic reset, // Synchronous, active high
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire motor_setpoint_pkg::step_pins_t step_pins, // Clock/direction or dual pulse inputs
	input wire logic index_mark, // Encoder index seen during auto setup
	input wire logic [31:0] actual_pos, // Measured position
	output logic [31:0] demand_pos, // Demand position
	output logic [15:0] torque_demand, // Applied torque preset
	output logic torque_active // Torque preset drives the motor
);

	// ******************************************************
	// Block state
	// ******************************************************
	// All state in one packed struct; the next value is built whole each clock
	motor_setpoint_pkg::state_t s_r;
	motor_setpoint_pkg::state_t s_nxt;

	// ******************************************************
	// Byte lanes
	// ******************************************************
	// Each select bit widened to one byte of write mask
	logic [31:0] lane_mask;
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign lane_mask[8 * g +: 8] = {8{wb_sel_i[g]}};
	end

	// ******************************************************
	// Combinational next state
	// ******************************************************
	always_comb begin
		logic req;
		logic wr;
		logic [31:0] rd;
		logic [31:0] wmask;
		logic closed_loop;
		logic mode_torque;
		logic mode_step;
		logic step_up;
		logic step_dn;
		logic signed [16:0] lim;
		logic signed [17:0] tsum;
		logic [31:0] perr;
		logic signed [55:0] moved;
		logic cycle_end;
		req = 1'b0;
		wr = 1'b0;
		rd = 32'h0000_0000;
		wmask = 32'h0000_0000;
		closed_loop = 1'b0;
		mode_torque = 1'b0;
		mode_step = 1'b0;
		step_up = 1'b0;
		step_dn = 1'b0;
		lim = 17'sh00000;
		tsum = 18'sh00000;
		perr = 32'h0000_0000;
		moved = 56'sh0;
		cycle_end = 1'b0;
		s_nxt = s_r;

		// ******************************************************
		// Bus slave
		// ******************************************************
		// Bus slave: one wait state, ack drops the cycle after it was given
		// A strobe held into its ack cycle is not taken again, so a write lands once
		req = wb_cyc_i && wb_stb_i && !s_r.wb_ack_r;
		wr = req && wb_we_i;
		s_nxt.wb_ack_r = req;
		wmask = lane_mask;

		// ******************************************************
		// Mode decode
		// ******************************************************
		// Closed loop only after a completed auto setup
		// An early closed-loop request is kept and takes hold once setup ends
		closed_loop = s_r.ctrl_r[`CTRL_CLOSED_LOOP] && s_r.setup_ok_r; // [R22]
		mode_torque = (s_r.mode_r == `MODE_TORQUE); // [R1]
		mode_step = (s_r.mode_r == `MODE_STEP_DIR); // [R9]

		// ******************************************************
		// Interpolation cycle
		// ******************************************************
		// Interpolation cycle: 1 ms base times period; other indices leave the timer idle
		// Counters clear on an unsupported index, so a later fix starts a clean cycle
		s_nxt.cycle_tick_r = 1'b0;
		if (s_r.cycle_index_r == `CYCLE_INDEX_MS) begin // [R7]
			if (s_r.base_cnt_r == 16'(BASE_CYCLES - 1)) begin
				s_nxt.base_cnt_r = 16'h0000;
				if (s_r.ms_cnt_r + 16'h0001 >= s_r.cycle_period_r) begin // [R7]
					s_nxt.ms_cnt_r = 16'h0000;
					cycle_end = 1'b1;
				end else begin
					s_nxt.ms_cnt_r = s_r.ms_cnt_r + 16'h0001;
				end
			end else begin
				s_nxt.base_cnt_r = s_r.base_cnt_r + 16'h0001;
			end
		end else begin
			s_nxt.base_cnt_r = 16'h0000;
			s_nxt.ms_cnt_r = 16'h0000;
		end
		s_nxt.cycle_tick_r = cycle_end;

		// ******************************************************
		// Step pulse inputs
		// ******************************************************
		// Rising edges on the pulse inputs
		// Previous levels reset low, the idle level, so no false edge follows reset
		s_nxt.pins_prev_r = {step_pins.pulse_a, step_pins.pulse_b};
		if (s_r.subtype_r == 1'b0) begin // [R16]
			if (step_pins.pulse_a && !s_r.pins_prev_r[1]) begin
				step_up = !step_pins.pulse_b;
				step_dn = step_pins.pulse_b;
			end
		end else begin // [R17]
			step_up = step_pins.pulse_a && !s_r.pins_prev_r[1]; // [R23]
			step_dn = step_pins.pulse_b && !s_r.pins_prev_r[0]; // [R23]
		end

		// ******************************************************
		// Step accumulation
		// ******************************************************
		// Pulses collect during the cycle; a pulse on the closing edge opens the next count
		// Leaving step mode drops a partial count instead of applying it later
		if (cycle_end) begin // [R12]
			s_nxt.step_acc_r = 24'(step_up) - 24'(step_dn);
			if (mode_step) begin
				moved = 56'(s_r.step_acc_r) * $signed({1'b0, s_r.step_scaled_r}); // [R10]
				s_nxt.demand_pos_r = s_r.demand_pos_r + moved[31:0];
			end
		end else if (mode_step) begin
			s_nxt.step_acc_r = s_r.step_acc_r + 24'(step_up) - 24'(step_dn); // [R10]
		end else begin
			s_nxt.step_acc_r = 24'sh0;
		end
		// Scale recomputed each clock; a zero denominator holds the old width
		if (s_r.step_den_r != 32'h0000_0000) begin
			s_nxt.step_scaled_r = s_r.step_num_r / s_r.step_den_r; // [R13]
		end

		// ******************************************************
		// Fieldbus synchronisation
		// ******************************************************
		// Sync: a preset arrived in the last cycle
		// A write in the same clock as the cycle end still counts as fresh
		if (wr && wb_adr_i == `OFS_TARGET_TORQUE) begin
			s_nxt.preset_fresh_r = 1'b1;
		end else if (cycle_end) begin
			s_nxt.preset_fresh_r = 1'b0;
		end
		if (cycle_end) begin
			s_nxt.synced_r = s_r.preset_fresh_r || (wr && wb_adr_i == `OFS_TARGET_TORQUE); // [R3]
		end

		// ******************************************************
		// Torque preset
		// ******************************************************
		// Torque: preset plus offset, clamped to the smaller limit
		// The negative bound mirrors the positive one, so the clamp is symmetric
		lim = (s_r.max_torque_r < s_r.max_current_r) ? $signed({1'b0, s_r.max_torque_r})
			: $signed({1'b0, s_r.max_current_r}); // [R6]
		tsum = 18'($signed(s_r.target_torque_r)) + 18'($signed(s_r.torque_offset_r)); // [R8]
		if (tsum > 18'(lim)) begin
			tsum = 18'(lim);
		end else if (tsum < -18'(lim)) begin
			tsum = -18'(lim);
		end
		s_nxt.follow_r = mode_torque && closed_loop; // [R2] [R4]
		if (mode_torque && closed_loop) begin // [R1]
			s_nxt.torque_demand_r = tsum[15:0];
		end else begin
			s_nxt.torque_demand_r = 16'h0000;
		end

		// ******************************************************
		// Following error
		// ******************************************************
		// Following error timer counts milliseconds outside the window
		// The count saturates so a long excursion cannot wrap below the timeout
		perr = s_r.demand_pos_r - actual_pos;
		if (perr[31]) begin
			perr = -perr;
		end
		if (mode_step && closed_loop && perr > s_r.err_window_r) begin // [R15]
			if (s_r.base_cnt_r == 16'h0000 && s_r.err_ms_r != 16'hFFFF) begin
				s_nxt.err_ms_r = s_r.err_ms_r + 16'h0001;
			end
			if (s_r.err_ms_r > s_r.err_timeout_r) begin
				s_nxt.follow_err_r = 1'b1; // [R15]
			end
		end else begin
			s_nxt.err_ms_r = 16'h0000;
			s_nxt.follow_err_r = 1'b0;
		end

		// ******************************************************
		// Auto setup
		// ******************************************************
		// Auto setup sequencer, a fixed run time stands in for the identification
		// Success is kept until reset; leaving the mode only rearms the start
		unique case (s_r.as_state_r)
			motor_setpoint_pkg::AS_IDLE: begin
				if (s_r.mode_r == `MODE_AUTOSETUP && wr && wb_adr_i == `OFS_CTRL && wb_sel_i[0]
					&& wb_dat_i[`CTRL_START] && !s_r.ctrl_r[`CTRL_START]) begin // [R18] [R19]
					s_nxt.as_state_r = motor_setpoint_pkg::AS_RUN;
					s_nxt.as_ms_r = 16'h0000;
					s_nxt.indexed_r = 1'b0;
					s_nxt.aligned_r = 1'b0;
				end
			end
			motor_setpoint_pkg::AS_RUN: begin
				if (index_mark) begin
					s_nxt.indexed_r = 1'b1; // [R20]
				end
				if (s_r.base_cnt_r == 16'h0000) begin
					s_nxt.as_ms_r = s_r.as_ms_r + 16'h0001;
				end
				if (s_r.as_ms_r >= `AUTOSETUP_MS) begin
					s_nxt.as_state_r = motor_setpoint_pkg::AS_DONE;
					s_nxt.aligned_r = 1'b1; // [R21]
					s_nxt.setup_ok_r = 1'b1; // [R22]
				end
			end
			motor_setpoint_pkg::AS_DONE: begin
				if (s_r.mode_r != `MODE_AUTOSETUP) begin
					s_nxt.as_state_r = motor_setpoint_pkg::AS_IDLE;
				end
			end
		endcase

		// ******************************************************
		// Register writes
		// ******************************************************
		// Byte lanes merge with the old value; read-only and unmapped offsets ignore writes
		if (wr) begin
			unique case (wb_adr_i)
				`OFS_MODE: begin
					s_nxt.mode_r = (wb_dat_i[7:0] & wmask[7:0]) | (s_r.mode_r & ~wmask[7:0]);
				end
				`OFS_CTRL: begin
					s_nxt.ctrl_r = (wb_dat_i[15:0] & wmask[15:0]) | (s_r.ctrl_r & ~wmask[15:0]);
				end
				`OFS_TARGET_TORQUE: begin
					s_nxt.target_torque_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.target_torque_r & ~wmask[15:0]); // [R5]
				end
				`OFS_MAX_TORQUE: begin
					s_nxt.max_torque_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.max_torque_r & ~wmask[15:0]);
				end
				`OFS_MAX_CURRENT: begin
					s_nxt.max_current_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.max_current_r & ~wmask[15:0]);
				end
				`OFS_TORQUE_OFFSET: begin
					s_nxt.torque_offset_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.torque_offset_r & ~wmask[15:0]);
				end
				`OFS_CYCLE_PERIOD: begin
					s_nxt.cycle_period_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.cycle_period_r & ~wmask[15:0]);
				end
				`OFS_CYCLE_INDEX: begin
					s_nxt.cycle_index_r = (wb_dat_i[7:0] & wmask[7:0])
						| (s_r.cycle_index_r & ~wmask[7:0]);
				end
				`OFS_STEP_NUM: begin
					s_nxt.step_num_r = (wb_dat_i & wmask) | (s_r.step_num_r & ~wmask);
				end
				`OFS_STEP_DEN: begin
					s_nxt.step_den_r = (wb_dat_i & wmask) | (s_r.step_den_r & ~wmask);
				end
				`OFS_SUBTYPE: begin
					if (wb_sel_i[0]) begin
						s_nxt.subtype_r = wb_dat_i[0];
					end
				end
				`OFS_ERR_WINDOW: begin
					s_nxt.err_window_r = (wb_dat_i & wmask) | (s_r.err_window_r & ~wmask);
				end
				`OFS_ERR_TIMEOUT: begin
					s_nxt.err_timeout_r = (wb_dat_i[15:0] & wmask[15:0])
						| (s_r.err_timeout_r & ~wmask[15:0]);
				end
				default: ;
			endcase
		end

		// ******************************************************
		// Register reads
		// ******************************************************
		// Read mux; status bit 12 means aligned in auto setup, following otherwise
		// Data is zero outside the ack cycle, which keeps a shared return bus quiet
		unique case (wb_adr_i)
			`OFS_MODE: rd = {24'h000000, s_r.mode_r};
			`OFS_CTRL: rd = {16'h0000, s_r.ctrl_r};
			`OFS_STATUS: begin
				rd[`ST_CLOSED_LOOP] = closed_loop;
				rd[`ST_SYNC] = s_r.synced_r; // [R3]
				rd[`ST_INDEXED] = (s_r.mode_r == `MODE_AUTOSETUP) && s_r.indexed_r; // [R20]
				rd[`ST_FOLLOW] = (s_r.mode_r == `MODE_AUTOSETUP) ? s_r.aligned_r : s_r.follow_r; // [R4] [R21]
				rd[`ST_FOLLOW_ERR] = s_r.follow_err_r; // [R15]
			end
			`OFS_TARGET_TORQUE: rd = {16'h0000, s_r.target_torque_r};
			`OFS_MAX_TORQUE: rd = {16'h0000, s_r.max_torque_r};
			`OFS_MAX_CURRENT: rd = {16'h0000, s_r.max_current_r};
			`OFS_TORQUE_OFFSET: rd = {16'h0000, s_r.torque_offset_r};
			`OFS_CYCLE_PERIOD: rd = {16'h0000, s_r.cycle_period_r};
			`OFS_CYCLE_INDEX: rd = {24'h000000, s_r.cycle_index_r};
			`OFS_STEP_NUM: rd = s_r.step_num_r;
			`OFS_STEP_DEN: rd = s_r.step_den_r;
			`OFS_SUBTYPE: rd = {31'h00000000, s_r.subtype_r};
			`OFS_ERR_WINDOW: rd = s_r.err_window_r;
			`OFS_ERR_TIMEOUT: rd = {16'h0000, s_r.err_timeout_r};
			`OFS_DEMAND_POS: rd = s_r.demand_pos_r;
			`OFS_TORQUE_DEMAND: rd = {16'h0000, s_r.torque_demand_r};
			`OFS_ACTUAL_POS: rd = actual_pos;
			default: rd = 32'h0000_0000; // Unmapped reads zero, still acknowledged
		endcase
		s_nxt.wb_dat_r = req ? rd : 32'h0000_0000;
	end

	// ******************************************************
	// State register
	// ******************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.step_num_r <= `RST_STEP_NUM;
			s_r.step_den_r <= `RST_STEP_DEN;
			s_r.step_scaled_r <= `RST_STEP_NUM;
			s_r.cycle_period_r <= `RST_CYCLE_PERIOD;
			s_r.cycle_index_r <= `CYCLE_INDEX_MS;
			s_r.max_torque_r <= `RST_MAX_TORQUE;
			s_r.max_current_r <= `RST_MAX_CURRENT;
			s_r.err_window_r <= `RST_ERR_WINDOW;
			s_r.err_timeout_r <= `RST_ERR_TIMEOUT;
			s_r.as_state_r <= motor_setpoint_pkg::AS_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ******************************************************
	// Outputs
	// ******************************************************
	// Outputs straight from the state flops
	assign wb_dat_o = s_r.wb_dat_r;
	assign wb_ack_o = s_r.wb_ack_r;
	assign demand_pos = s_r.demand_pos_r;
	assign torque_demand = s_r.torque_demand_r;
	assign torque_active = s_r.follow_r;

endmodule : motor_setpoint_mode_logic
`default_nettype wire

// *** motor_setpoint_mode_logic_tb_top.sv ***
// Self-checking bench for motor_setpoint_mode_logic.
// Assumes BASE_CYCLES shortened to 10 clocks per millisecond.
`timescale 1ns/1ns
`default_nettype none
`include "motor_setpoint_consts.svh"
module motor_setpoint_mode_logic_tb_top;
	logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, torque_active, index_mark;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, demand_pos, p0, st, act_pos;
	logic [15:0] torque_demand;
	motor_setpoint_pkg::step_pins_t step_pins;
	int n_fail = 0;
	int checks = 0;
	int cyc_cnt = 0;
	logic [15:0] tgt [3] = '{16'h012C, 16'hFED4, 16'h0064};
	logic [15:0] ofs [3] = '{16'h0000, 16'h0000, 16'h0014};
	logic [15:0] exp_t [3] = '{16'h0096, 16'hFF6A, 16'h0078};
	motor_setpoint_mode_logic #(.BASE_CYCLES(10)) dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_pins(step_pins), .index_mark(index_mark),
		.actual_pos(act_pos), .demand_pos(demand_pos), .torque_demand(torque_demand), .torque_active(torque_active));
	step_source_model gen (.clk(clk), .pins(step_pins));
	// ************
	// Bus and report
	// ************
	task automatic end_sim();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle: hold everything until ack is seen at an edge
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		// Waits for ack; with no ack only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer
	task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
		logic [31:0] dummy;
		wb_xfer(1'b1, adr, wd, dummy);
	endtask : wb_wr
	task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		wb_xfer(1'b0, adr, 32'h0, rd);
		chk(rd, exp);
	endtask : wb_rd
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cut a hang short well past the expected run length
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		reset = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		index_mark = 1'b1;
		act_pos = 32'h0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		wb_rd(`OFS_STEP_NUM, 32'h0000_0080);
		wb_rd(`OFS_STEP_DEN, 32'h0000_0001);
		wb_rd(`OFS_CYCLE_INDEX, 32'h0000_00FD);
		wb_rd(`OFS_SUBTYPE, 32'h0);
		wb_rd(8'h80, 32'h0);
		$display("test reset done");
		// Closed loop must be refused before auto setup
		wb_wr(`OFS_MODE, 32'h0A);
		wb_wr(`OFS_CTRL, 32'h01);
		wb_wr(`OFS_TARGET_TORQUE, 32'h64);
		repeat (30) @(posedge clk);
		chk({31'h0, torque_active}, 32'h0);
		chk({16'h0, torque_demand}, 32'h0);
		$display("test refuse done");
		wb_wr(`OFS_MODE, 32'hFE);
		wb_wr(`OFS_CTRL, 32'h11);
		st = 32'h0;
		for (int i = 0; i < 1000 && st[12] !== 1'b1; i++) wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
		chk({31'h0, st[12]}, 32'h1);
		chk({31'h0, st[10]}, 32'h1);
		$display("test setup done");
		wb_wr(`OFS_MODE, 32'h0A);
		wb_wr(`OFS_MAX_TORQUE, 32'hC8);
		wb_wr(`OFS_MAX_CURRENT, 32'h96);
		for (int i = 0; i < 3; i++) begin
			wb_wr(`OFS_TORQUE_OFFSET, {16'h0, ofs[i]});
			wb_wr(`OFS_TARGET_TORQUE, {16'h0, tgt[i]});
			// Nine clocks after the write a 10-clock cycle has closed on the fresh preset
			repeat (7) @(posedge clk);
			wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
			chk({31'h0, st[8]}, 32'h1);
			repeat (20) @(posedge clk);
			chk({16'h0, torque_demand}, {16'h0, exp_t[i]});
		end
		wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
		chk({31'h0, st[12]}, 32'h1);
		chk({31'h0, st[0]}, 32'h1);
		$display("test torque done");
		wb_wr(`OFS_MODE, 32'hFF);
		wb_wr(`OFS_CYCLE_PERIOD, 32'h2);
		chk({31'h0, torque_active}, 32'h0);
		p0 = demand_pos;
		gen.send(2, 1'b1, 1'b0);
		gen.send(4, 1'b0, 1'b0);
		repeat (50) @(posedge clk);
		chk(demand_pos - p0, 32'h100);
		wb_wr(`OFS_SUBTYPE, 32'h1);
		wb_wr(`OFS_STEP_NUM, 32'h200);
		gen.send(3, 1'b0, 1'b1);
		gen.send(1, 1'b1, 1'b1);
		repeat (50) @(posedge clk);
		chk(demand_pos - p0, 32'h500);
		$display("test step done");
		act_pos <= demand_pos; // Inside the error window
		repeat (20) @(posedge clk);
		wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
		chk({31'h0, st[13]}, 32'h0);
		act_pos <= demand_pos + 32'h0000_0200; // Outside the window
		repeat (50) @(posedge clk);
		wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
		chk({31'h0, st[13]}, 32'h0);
		repeat (100) @(posedge clk);
		wb_xfer(1'b0, `OFS_STATUS, 32'h0, st);
		chk({31'h0, st[13]}, 32'h1);
		chk({31'h0, st[8]}, 32'h0);
		$display("test error done");
		end_sim();
	end
endmodule : motor_setpoint_mode_logic_tb_top
`default_nettype wire

// *** motor_setpoint_pkg.sv ***
// Types for motor_setpoint_mode_logic.
// Assumes the constants header is compiled alongside.
package motor_setpoint_pkg;

	// Auto setup sequencer states
	typedef enum logic [1:0] {AS_IDLE, AS_RUN, AS_DONE} autosetup_state_t;

	// Step pulse inputs as one group
	typedef struct packed {
		logic pulse_a; // Clock input, or first pulse input
		logic pulse_b; // Direction input, or second pulse input
	} step_pins_t;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] mode_r;
		logic [15:0] ctrl_r;
		logic [15:0] target_torque_r;
		logic [15:0] max_torque_r;
		logic [15:0] max_current_r;
		logic [15:0] torque_offset_r;
		logic [15:0] cycle_period_r;
		logic [7:0] cycle_index_r;
		logic [31:0] step_num_r;
		logic [31:0] step_den_r;
		logic subtype_r;
		logic [31:0] err_window_r;
		logic [15:0] err_timeout_r;
		logic [31:0] demand_pos_r;
		logic [15:0] torque_demand_r;
		logic [15:0] base_cnt_r;
		logic [15:0] ms_cnt_r;
		logic cycle_tick_r;
		logic signed [23:0] step_acc_r;
		logic [1:0] pins_prev_r;
		logic synced_r;
		logic preset_fresh_r;
		logic follow_r;
		logic follow_err_r;
		logic [15:0] err_ms_r;
		logic indexed_r;
		logic aligned_r;
		logic setup_ok_r;
		autosetup_state_t as_state_r;
		logic [15:0] as_ms_r;
		logic wb_ack_r;
		logic [31:0] wb_dat_r;
		logic [31:0] step_scaled_r;
	} state_t;

endpackage : motor_setpoint_pkg

// *** step_source_model.sv ***
// Behavioural positioning controller driving the step inputs.
// Assumes calls start just after a rising clock edge of a 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module step_source_model #(
	parameter int ON_CYC = 5,
	parameter int OFF_CYC = 20,
	parameter int DIR_SETTLE = 875
) (
	input wire logic clk, // Clock
	output motor_setpoint_pkg::step_pins_t pins // Step inputs of the block
);
	initial pins = '0;
	// Pulses of 200 ns high in a 1 us period keep within the allowed rate
	task automatic send(input int n, input logic neg, input logic dual);
		if (!dual && pins.pulse_b !== neg) begin
			pins.pulse_b <= neg;
			repeat (DIR_SETTLE) @(posedge clk);
		end
		repeat (n) begin
			if (dual && neg) pins.pulse_b <= 1'b1;
			else pins.pulse_a <= 1'b1;
			repeat (ON_CYC) @(posedge clk);
			if (dual) pins <= '0;
			else pins.pulse_a <= 1'b0;
			repeat (OFF_CYC) @(posedge clk);
		end
	endtask : send
endmodule : step_source_model
`default_nettype wire
